// [core/cfg_zone_cmd.sv]
`timescale 1ns/1ps
`include "cfg_zone_defs.svh"

// ========================================
// response byte fifo
module resp_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 16
) (
    // clock and reset
    input  wire logic             clock,
    input  wire logic             nrst,
    // fill side
    input  wire logic             in_valid,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  in_ready,
    // drain side
    output logic                  out_valid,
    output logic [WIDTH-1:0]      out_data,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);
    generate
        if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
            $error("fifo depth must be a power of two");
        end
    endgenerate
    logic [WIDTH-1:0] store [DEPTH];
    logic [AW-1:0]    wp_r;
    logic [AW-1:0]    rp_r;
    logic [AW:0]      cnt_r;
    logic             push;
    logic             pop;
    assign in_ready  = cnt_r != (AW+1)'(DEPTH);
    assign out_valid = cnt_r != '0;
    assign out_data  = store[rp_r];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    always_ff @(posedge clock) begin
        if (push) begin
            store[wp_r] <= in_data;
        end
    end
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
        end else begin
            wp_r  <= wp_r + AW'(push);
            rp_r  <= rp_r + AW'(pop);
            cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// ========================================
// configuration zone command handler
module cfg_zone_cmd import cfg_zone_pkg::*; #(
    parameter int BUF_DEPTH  = 22,
    parameter int FIFO_DEPTH = 16
) (
    // clock and reset
    input  wire logic        clock,
    input  wire logic        nrst,
    // card state
    input  wire logic        card_active,
    input  wire logic [3:0]  card_id,
    input  mode_e            comm_mode,
    input  wire logic        secret_ok,
    input  wire logic        write_ok,
    input  wire logic        fuse_access_ok,
    output logic [3:0]       fuse_state,
    // command bytes, crc already checked
    input  wire logic        rx_valid,
    input  rx_byte_s         rx,
    output logic             rx_ready,
    // crypto engine
    output logic             mac_check,
    output logic [15:0]      mac_word,
    input  wire logic        mac_ok,
    output logic             crypto_rst,
    // read permission lookup
    output logic [7:0]       peek_addr,
    input  wire logic        peek_ok,
    // response bytes, crc appended downstream
    output logic             tx_valid,
    output tx_byte_s         tx,
    input  wire logic        tx_ready
);
    generate
        if (BUF_DEPTH < 22) begin : g_chk
            $error("buffer must hold a full page plus header and checksum");
        end
    endgenerate

    // ========================================
    // state
    state_e      st_r;
    logic [7:0]  buf_r [BUF_DEPTH];
    logic [5:0]  cnt_r;
    logic [7:0]  status_r;
    logic        nack_r;
    logic        is_read_r;
    logic        subst_r;
    logic [3:0]  fuse_r;
    logic [3:0]  i_r;
    logic [8:0]  tx_i_r;
    logic [7:0]  mem [256];
    logic        crypto_rst_r;

    logic [7:0]  hdr, op_sel, addr, len;
    logic [5:0]  data_n;
    logic [7:0]  wr_addr;
    logic [7:0]  wr_byte;
    assign hdr     = buf_r[0];
    assign op_sel  = buf_r[1];
    assign addr    = buf_r[2];
    assign len     = buf_r[3];
    assign data_n  = cnt_r - `HDR_BYTES;
    assign wr_addr = {addr[7:4], addr[3:0] + i_r};
    assign wr_byte = buf_r[`DATA_IDX + 5'(i_r)];
    assign mac_word = {buf_r[5'(len[3:0]) + 5'd5], buf_r[5'(len[3:0]) + 5'd6]};
    assign fuse_state = fuse_r;
    assign rx_ready   = st_r == S_RECV;
    assign crypto_rst = crypto_rst_r;

    // ========================================
    // command decode
    logic        ex_silent, ex_nack, ex_write, ex_fuse, ex_macfail, ex_read;
    logic [7:0]  ex_code;
    logic [1:0]  fidx;
    logic        fvalid;
    logic [3:0]  fbit;
    always_comb begin
        fvalid = 1'b1;
        fidx   = 2'd0;
        unique case (addr)
            `FUSE_LOCK_ADDR: fidx = 2'd3;
            `FUSE_HI_ADDR:   fidx = 2'd2;
            `FUSE_MID_ADDR:  fidx = 2'd1;
            `FUSE_LO_ADDR:   fidx = 2'd0;
            default:         fvalid = 1'b0;
        endcase
        fbit = 4'h1 << fidx;
    end

    always_comb begin
        ex_silent = !card_active || hdr[7:4] != card_id || cnt_r < `HDR_BYTES
                    || (hdr[3:0] != `CMD_WRITE && hdr[3:0] != `CMD_READ);
        ex_code    = `ST_OK;
        ex_nack    = 1'b1;
        ex_write   = 1'b0;
        ex_fuse    = 1'b0;
        ex_macfail = 1'b0;
        ex_read    = 1'b0;
        mac_check  = 1'b0;
        if (hdr[3:0] == `CMD_READ) begin
            if (op_sel != `SEL_NORMAL) ex_code = `ST_BAD_SEL;
            else if (cnt_r != `HDR_BYTES || len > `READ_MAX_L) ex_code = `ST_BAD_LEN;
            else begin
                ex_nack = 1'b0;
                ex_read = 1'b1;
            end
        end else begin
            unique case (op_sel)
                `SEL_NORMAL: begin
                    if (len > `PAGE_MAX_L || data_n != 6'(len[3:0]) + 6'd1)
                        ex_code = `ST_BAD_LEN;
                    else if (!write_ok) ex_code = `ST_DENIED;
                    else begin
                        ex_nack  = 1'b0;
                        ex_write = 1'b1;
                    end
                end
                `SEL_MAC: begin
                    if (comm_mode != MODE_CIPHER) ex_code = `ST_DENIED;
                    else if (len > `PAGE_MAX_L
                             || data_n != 6'(len[3:0]) + 6'd1 + `MAC_BYTES)
                        ex_code = `ST_BAD_LEN;
                    else if (!write_ok) ex_code = `ST_DENIED;
                    else begin
                        mac_check = st_r == S_EXEC && !ex_silent;
                        if (!mac_ok) begin
                            ex_code    = `ST_MAC_FAIL;
                            ex_macfail = 1'b1;
                        end else begin
                            ex_code  = `ST_MAC_DONE;
                            ex_nack  = 1'b0;
                            ex_write = 1'b1;
                        end
                    end
                end
                `SEL_FUSE: begin
                    if (!fvalid) ex_code = `ST_BAD_ADDR;
                    else if (len != 8'h00 || data_n != 6'd1) ex_code = `ST_BAD_LEN;
                    else if (!secret_ok) ex_code = `ST_NO_SECRET;
                    else if (!fuse_access_ok) ex_code = `ST_FUSE_DENY;
                    // lower fuses must already be blown before this one
                    else if ((fuse_r & (fbit - 4'h1)) != 4'h0) ex_code = `ST_FUSE_ORDER;
                    else begin
                        ex_code = {4'h0, fuse_r & ~fbit};
                        ex_nack = 1'b0;
                        ex_fuse = 1'b1;
                    end
                end
                default: ex_code = `ST_BAD_SEL;
            endcase
        end
    end

    // ========================================
    // response stream
    logic [8:0]  off;
    logic        in_data;
    logic        push;
    logic        f_ready;
    logic        is_last;
    tx_byte_s    item;
    assign off       = tx_i_r - 9'd2;
    assign in_data   = is_read_r && tx_i_r >= 9'd2 && off <= {1'b0, len};
    assign peek_addr = addr + off[7:0];
    assign is_last   = tx_i_r != 9'd0 && tx_i_r != 9'd1 && !in_data;
    assign push      = st_r == S_TX;
    always_comb begin
        item.cipher = 1'b0;
        item.last   = is_last;
        if (tx_i_r == 9'd0) item.data = hdr;
        else if (tx_i_r == 9'd1) item.data = nack_r ? `CODE_NACK : `CODE_ACK;
        else if (in_data) begin
            item.data   = peek_ok ? mem[peek_addr] : {4'h0, fuse_r};
            item.cipher = peek_ok && comm_mode != MODE_NORMAL
                          && peek_addr >= `SECRET_FIRST && peek_addr <= `SECRET_LAST;
        end else item.data = (is_read_r && subst_r) ? `ST_DENIED : status_r;
    end

    resp_fifo #(.WIDTH($bits(tx_byte_s)), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clock    (clock),
        .nrst     (nrst),
        .in_valid (push),
        .in_data  (item),
        .in_ready (f_ready),
        .out_valid(tx_valid),
        .out_data (tx),
        .out_ready(tx_ready)
    );

    // ========================================
    // sequencing
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            st_r      <= S_RECV;
            cnt_r     <= '0;
            status_r  <= `ST_OK;
            nack_r    <= 1'b0;
            is_read_r <= 1'b0;
            subst_r   <= 1'b0;
            i_r       <= '0;
            tx_i_r    <= '0;
        end else begin
            unique case (st_r)
                S_RECV: if (rx_valid) begin
                    cnt_r <= (cnt_r == 6'h3f) ? cnt_r : cnt_r + 6'd1;
                    if (rx.last) begin
                        if (rx.err) cnt_r <= '0;
                        else st_r <= S_EXEC;
                    end
                end
                S_EXEC: begin
                    if (ex_silent) begin
                        st_r  <= S_RECV;
                        cnt_r <= '0;
                    end else begin
                        status_r  <= ex_code;
                        nack_r    <= ex_nack;
                        is_read_r <= ex_read;
                        subst_r   <= 1'b0;
                        i_r       <= '0;
                        tx_i_r    <= '0;
                        st_r      <= ex_write ? S_WR : S_TX;
                    end
                end
                S_WR: begin
                    i_r <= i_r + 4'd1;
                    if (i_r == len[3:0]) begin
                        i_r  <= '0;
                        st_r <= S_VF;
                    end
                end
                S_VF: begin
                    if (mem[wr_addr] != wr_byte) begin
                        status_r <= `ST_MISMATCH;
                        nack_r   <= 1'b1;
                    end
                    i_r <= i_r + 4'd1;
                    if (i_r == len[3:0]) st_r <= S_TX;
                end
                S_TX: if (f_ready) begin
                    tx_i_r <= tx_i_r + 9'd1;
                    if (in_data && !peek_ok) subst_r <= 1'b1;
                    if (is_last) begin
                        st_r  <= S_RECV;
                        cnt_r <= '0;
                    end
                end
            endcase
        end
    end

    // command capture; contents need no reset
    always_ff @(posedge clock) begin
        if (st_r == S_RECV && rx_valid && cnt_r < 6'(BUF_DEPTH)) begin
            buf_r[cnt_r[4:0]] <= rx.data;
        end
    end

    always_ff @(posedge clock) begin
        if (st_r == S_WR) begin
            mem[wr_addr] <= wr_byte;
        end
    end

    // fuses only ever clear, one per command
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) fuse_r <= `FUSE_RESET;
        else if (st_r == S_EXEC && !ex_silent && ex_fuse) fuse_r <= fuse_r & ~fbit;
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) crypto_rst_r <= 1'b0;
        else crypto_rst_r <= st_r == S_EXEC && !ex_silent && ex_macfail;
    end

    // ========================================
    // checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    fuse_otp_a: assert property ((~$past(fuse_r) & fuse_r) == 4'h0)
        else $error("fuse returned to unprogrammed");
    fuse_single_a: assert property ($countones($past(fuse_r) ^ fuse_r) <= 1)
        else $error("more than one fuse changed");
    err_drop_a: assert property (st_r == S_RECV && rx_valid && rx.last && rx.err
        |=> (st_r == S_RECV && !push) [*2])
        else $error("errored frame got a response");
    inactive_quiet_a: assert property (st_r == S_EXEC && !card_active |=> st_r == S_RECV)
        else $error("inactive card answered");
    echo_id_a: assert property (push && tx_i_r == 9'd0 |-> item.data[7:4] == card_id)
        else $error("response lacks card id");
    bad_sel_a: assert property (st_r == S_EXEC && !ex_silent && hdr[3:0] == `CMD_WRITE
        && op_sel != `SEL_NORMAL && op_sel != `SEL_FUSE && op_sel != `SEL_MAC
        |=> status_r == `ST_BAD_SEL && nack_r)
        else $error("bad selector not rejected");
    page_len_a: assert property (st_r == S_EXEC && !ex_silent && hdr[3:0] == `CMD_WRITE
        && op_sel == `SEL_NORMAL && len > `PAGE_MAX_L |=> status_r == `ST_BAD_LEN)
        else $error("oversize write accepted");
    page_wrap_a: assert property (st_r == S_WR |-> wr_addr[7:4] == addr[7:4])
        else $error("write left its page");
    cipher_only_a: assert property (push && item.cipher
        |-> in_data && comm_mode != MODE_NORMAL && peek_addr >= `SECRET_FIRST)
        else $error("non secret byte enciphered");
    mac_reset_a: assert property (crypto_rst |-> status_r == `ST_MAC_FAIL && nack_r
        ##1 !crypto_rst)
        else $error("engine reset without checksum failure");
    read_inc_a: assert property (push && f_ready && in_data && off < {1'b0, len}
        |=> peek_addr == $past(peek_addr) + 8'd1)
        else $error("read address did not advance");

    read_done_c: cover property (st_r == S_TX && is_read_r && is_last && f_ready);
    fuse_prog_c: cover property (st_r == S_EXEC && ex_fuse && !ex_silent);
    mac_write_c: cover property (st_r == S_VF ##1 st_r == S_TX && status_r == `ST_MAC_DONE);
    stall_c: cover property (st_r == S_TX && !f_ready);
endmodule

// [core/cfg_zone_defs.svh]
`ifndef CFG_ZONE_DEFS_SVH
`define CFG_ZONE_DEFS_SVH
`define CMD_WRITE      4'h4
`define CMD_READ       4'h6
`define SEL_NORMAL     8'h00
`define SEL_FUSE       8'h01
`define SEL_MAC        8'h08
`define ST_OK          8'h00
`define ST_BAD_SEL     8'ha1
`define ST_BAD_ADDR    8'ha2
`define ST_BAD_LEN     8'ha3
`define ST_MAC_DONE    8'hb0
`define ST_DENIED      8'hba
`define ST_MAC_FAIL    8'hc9
`define ST_NO_SECRET   8'hd9
`define ST_FUSE_DENY   8'hdf
`define ST_FUSE_ORDER  8'he9
`define ST_MISMATCH    8'hed
`define CODE_ACK       8'h06
`define CODE_NACK      8'h15
`define FUSE_LOCK_ADDR 8'h07
`define FUSE_HI_ADDR   8'h06
`define FUSE_MID_ADDR  8'h04
`define FUSE_LO_ADDR   8'h00
`define FUSE_RESET     4'hf
`define PAGE_MAX_L     8'h0f
`define READ_MAX_L     8'hf0
`define SECRET_FIRST   8'hb0
`define SECRET_LAST    8'hff
`define HDR_BYTES      6'd4
`define MAC_BYTES      6'd2
`define DATA_IDX       5'd4
`endif

// [core/cfg_zone_pkg.sv]
package cfg_zone_pkg;
    typedef struct packed {
        logic [7:0] data;
        logic       last;
        logic       err;
    } rx_byte_s;
    typedef struct packed {
        logic [7:0] data;
        logic       last;
        logic       cipher;
    } tx_byte_s;
    typedef enum logic [1:0] {MODE_NORMAL, MODE_AUTH, MODE_CIPHER} mode_e;
    typedef enum logic [2:0] {S_RECV, S_EXEC, S_WR, S_VF, S_TX} state_e;
endpackage

// [tb/cfg_zone_cmd_tb.sv]
`timescale 1ns/1ps

// ========================================
// bench for the configuration zone command handler
module cfg_zone_cmd_tb import cfg_zone_pkg::*;;
    logic       clock, nrst, card_active, secret_ok, write_ok, fuse_access_ok;
    logic       rx_ready, rx_valid, mac_check, mac_ok, crypto_rst, peek_ok;
    logic       tx_valid, tx_ready;
    logic [3:0] card_id, fuse_state;
    logic [7:0] peek_addr;
    logic [15:0] mac_word, mac_seen;
    mode_e      comm_mode;
    rx_byte_s   rx;
    tx_byte_s   tx;
    int         fails = 0;
    int         comparisons = 0;
    int         rst_pulses = 0;

    cfg_zone_cmd cfg_zone_cmd_inst (.clock(clock), .nrst(nrst), .card_active(card_active),
        .card_id(card_id), .comm_mode(comm_mode), .secret_ok(secret_ok), .write_ok(write_ok),
        .fuse_access_ok(fuse_access_ok), .fuse_state(fuse_state), .rx_valid(rx_valid),
        .rx(rx), .rx_ready(rx_ready), .mac_check(mac_check), .mac_word(mac_word),
        .mac_ok(mac_ok), .crypto_rst(crypto_rst), .peek_addr(peek_addr),
        .peek_ok(peek_ok), .tx_valid(tx_valid), .tx(tx), .tx_ready(tx_ready));

    reader_model reader_model_inst (.clock(clock), .rx_ready(rx_ready), .rx_valid(rx_valid),
        .rx(rx), .tx_valid(tx_valid), .tx(tx), .tx_ready(tx_ready));

    // only address 20 is closed to reading
    assign peek_ok = (peek_addr != 8'h20);

    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    always @(posedge clock) begin
        if (mac_check === 1'b1) mac_seen <= mac_word;
        if (crypto_rst === 1'b1) rst_pulses <= rst_pulses + 1;
    end

    // ========================================
    // helpers
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic frame(input logic [7:0] c[$], input logic [7:0] r[$],
                         input logic [15:0] cmask);
        int n;
        n = 0;
        reader_model_inst.rq.delete();
        reader_model_inst.send(c, 1'b0);
        while (n < 600 && !(reader_model_inst.rq.size() > 0 &&
               reader_model_inst.rq[reader_model_inst.rq.size() - 1][1])) begin
            @(posedge clock);
            n++;
        end
        chk("resp length", 16'(reader_model_inst.rq.size()), 16'(r.size()));
        for (int i = 0; i < r.size() && i < reader_model_inst.rq.size(); i++) begin
            chk("resp byte", {6'h0, reader_model_inst.rq[i]},
                {6'h0, r[i], 1'(i == r.size() - 1), cmask[i]});
        end
    endtask

    task automatic quiet(input logic [7:0] c[$], input logic bad);
        reader_model_inst.rq.delete();
        reader_model_inst.send(c, bad);
        repeat (60) @(posedge clock);
        chk("silence", 16'(reader_model_inst.rq.size()), 16'h0000);
    endtask

    task automatic tally_and_finish;
        if (fails == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // ========================================
    // scenarios
    task automatic write_read;
        reader_model_inst.slow = 1'b1;
        frame('{8'h34, 8'h00, 8'h1e, 8'h02, 8'h11, 8'h22, 8'h33}, '{8'h34, 8'h06, 8'h00}, 0);
        frame('{8'h36, 8'h00, 8'h10, 8'h00}, '{8'h36, 8'h06, 8'h33, 8'h00}, 0);
        frame('{8'h36, 8'h00, 8'h1e, 8'h02},
              '{8'h36, 8'h06, 8'h11, 8'h22, 8'h0f, 8'hba}, 0);
        reader_model_inst.slow = 1'b0;
    endtask

    task automatic write_errors;
        logic [7:0] q[$];
        q = '{8'h34, 8'h00, 8'h40, 8'h10};
        repeat (17) q.push_back(8'h01);
        frame(q, '{8'h34, 8'h15, 8'ha3}, 0);
        frame('{8'h34, 8'h05, 8'h40, 8'h00, 8'h01}, '{8'h34, 8'h15, 8'ha1}, 0);
        write_ok <= 1'b0;
        frame('{8'h34, 8'h00, 8'h40, 8'h00, 8'h01}, '{8'h34, 8'h15, 8'hba}, 0);
        write_ok <= 1'b1;
    endtask

    task automatic silent_cases;
        quiet('{8'h34, 8'h00, 8'h40, 8'h00, 8'h01}, 1'b1);
        quiet('{8'h54, 8'h00, 8'h40, 8'h00, 8'h01}, 1'b0);
        card_active <= 1'b0;
        quiet('{8'h36, 8'h00, 8'h10, 8'h00}, 1'b0);
        card_active <= 1'b1;
    endtask

    task automatic mac_write;
        frame('{8'h34, 8'h00, 8'h30, 8'h01, 8'h00, 8'h00}, '{8'h34, 8'h06, 8'h00}, 0);
        frame('{8'h34, 8'h08, 8'h30, 8'h00, 8'h44, 8'h12, 8'h34},
              '{8'h34, 8'h15, 8'hba}, 0);
        comm_mode <= MODE_CIPHER;
        mac_ok <= 1'b0;
        frame('{8'h34, 8'h08, 8'h31, 8'h00, 8'h55, 8'h12, 8'h34},
              '{8'h34, 8'h15, 8'hc9}, 0);
        chk("mac word", mac_seen, 16'h1234);
        chk("engine reset", 16'(rst_pulses), 16'h0001);
        mac_ok <= 1'b1;
        frame('{8'h34, 8'h08, 8'h30, 8'h00, 8'h44, 8'hab, 8'hcd},
              '{8'h34, 8'h06, 8'hb0}, 0);
        chk("mac word", mac_seen, 16'habcd);
        frame('{8'h36, 8'h00, 8'h30, 8'h01}, '{8'h36, 8'h06, 8'h44, 8'h00, 8'h00}, 0);
        comm_mode <= MODE_NORMAL;
    endtask

    task automatic cipher_read;
        frame('{8'h34, 8'h00, 8'hb0, 8'h00, 8'h77}, '{8'h34, 8'h06, 8'h00}, 0);
        frame('{8'h36, 8'h00, 8'hb0, 8'h00}, '{8'h36, 8'h06, 8'h77, 8'h00}, 0);
        comm_mode <= MODE_AUTH;
        frame('{8'h36, 8'h00, 8'hb0, 8'h00}, '{8'h36, 8'h06, 8'h77, 8'h00}, 16'h0004);
        comm_mode <= MODE_NORMAL;
    endtask

    // wrong order, no password, denied, bad address, then all four in order
    task automatic fuse_program;
        logic [7:0] fa[9];
        logic [7:0] fs[9];
        fa = '{8'h07, 8'h00, 8'h00, 8'h05, 8'h00, 8'h04, 8'h06, 8'h07, 8'h00};
        fs = '{8'he9, 8'hd9, 8'hdf, 8'ha2, 8'h0e, 8'h0c, 8'h08, 8'h00, 8'h00};
        frame('{8'h34, 8'h01, 8'h00, 8'h01, 8'haa, 8'hbb}, '{8'h34, 8'h15, 8'ha3}, 0);
        for (int i = 0; i < 9; i++) begin
            secret_ok <= (i != 1);
            fuse_access_ok <= (i != 2);
            comm_mode <= (i == 4) ? MODE_CIPHER : (i == 5) ? MODE_AUTH : MODE_NORMAL;
            frame('{8'h34, 8'h01, fa[i], 8'h00, 8'h5a ^ 8'(i)},
                  '{8'h34, (i < 4) ? 8'h15 : 8'h06, fs[i]}, 0);
            chk("fuses", {12'h000, fuse_state},
                {12'h000, (i < 4) ? 4'hf : fs[i][3:0]});
        end
    endtask

    // ========================================
    // main sequence
    initial begin
        nrst = 1'b0;
        card_active = 1'b1;
        card_id = 4'h3;
        comm_mode = MODE_NORMAL;
        secret_ok = 1'b1;
        write_ok = 1'b1;
        fuse_access_ok = 1'b1;
        mac_ok = 1'b1;
        repeat (2) @(posedge clock);
        nrst <= 1'b1;
        @(posedge clock);
        chk("reset fuses", {12'h000, fuse_state}, 16'h000f);
        chk("reset tx_valid", {15'h0, tx_valid}, 16'h0000);
        write_read;
        write_errors;
        silent_cases;
        mac_write;
        cipher_read;
        fuse_program;
        tally_and_finish;
    end

    // a whole run needs well under 5000 cycles
    initial begin
        repeat (20000) @(posedge clock);
        fails++;
        tally_and_finish;
    end
endmodule

// [tb/reader_model.sv]
`timescale 1ns/1ps

// ========================================
// reader side: sends command frames, gathers response bytes
module reader_model import cfg_zone_pkg::*; (
    // clock
    input  wire logic clock,
    // command path
    input  wire logic rx_ready,
    output logic      rx_valid,
    output rx_byte_s  rx,
    // response path
    input  wire logic tx_valid,
    input  tx_byte_s  tx,
    output logic      tx_ready
);
    logic [9:0] rq[$];
    logic       slow = 1'b0;
    logic [1:0] cnt = 2'h0;

    initial begin
        rx_valid = 1'b0;
        rx = '0;
        tx_ready = 1'b1;
    end

    // a slow reader holds ready low half the time
    always @(posedge clock) begin
        cnt <= cnt + 2'h1;
        tx_ready <= !slow || cnt[1];
        if (tx_valid && tx_ready) begin
            rq.push_back(tx);
        end
    end

    // crc failure shows as err on the closing byte only
    task automatic send(input logic [7:0] b[$], input logic bad);
        int l;
        l = b.size() - 1;
        @(posedge clock);
        for (int i = 0; i <= l; i++) begin
            rx_valid <= 1'b1;
            rx <= '{data: b[i], last: 1'(i == l), err: bad && (i == l)};
            @(posedge clock);
            while (!rx_ready) begin
                @(posedge clock);
            end
        end
        rx_valid <= 1'b0;
        // idle lines never repeat the last byte
        rx <= '{data: ~b[l], last: 1'b0, err: 1'b0};
    endtask
endmodule
